// ---- src/ued_echo_timer.sv ----
/*
 Ultrasonic echo delay timer: Avalon-MM slave, pin mux, two delay engines,
 tick base and interrupt. Assumes pins arrive asynchronously to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ued_echo_timer #(
    parameter int NPORTS = 4,
    parameter int TIMEOUT_TICKS = ued_pkg::TIMEOUT_TICKS_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic [NPORTS*ued_pkg::PORT_BITS-1:0] pinIn,
    input wire logic echoCaptureIn,
    output logic [NPORTS*ued_pkg::PORT_BITS-1:0] trigOut,
    output logic [NPORTS*ued_pkg::PORT_BITS-1:0] trigOe,
    output logic [15:0] pinSetup
);
    localparam int NPINS = NPORTS * ued_pkg::PORT_BITS;

    if (NPORTS < 1 || NPORTS > 8 || TIMEOUT_TICKS < 1) begin : g_bad_params
        $error("ued_echo_timer: unsupported NPORTS or TIMEOUT_TICKS");
    end
    if (ued_pkg::FINE_WIDTH < 64 || ued_pkg::COARSE_WIDTH < 32) begin : g_narrow
        $error("ued_echo_timer: counters too narrow"); // [R10]
    end

    // 12 MHz tick from 100 MHz by phase accumulation; jitter one clk
    logic [6:0] tickAcc;
    logic tick;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tickAcc <= 7'h00;
            tick <= 1'b0;
        end else if (tickAcc + 7'(ued_pkg::TICK_MHZ)
                     >= 7'(ued_pkg::CLK_MHZ)) begin
            tickAcc <= tickAcc + 7'(ued_pkg::TICK_MHZ) - 7'(ued_pkg::CLK_MHZ);
            tick <= 1'b1; // [R5]
        end else begin
            tickAcc <= tickAcc + 7'(ued_pkg::TICK_MHZ);
            tick <= 1'b0;
        end
    end

    // two-flop synchronisers; only the second stage is read
    logic [NPINS-1:0] pinMeta;
    logic [NPINS-1:0] pinSync;
    logic capMeta;
    logic capSync;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinMeta <= '0;
            pinSync <= '0;
            capMeta <= 1'b0;
            capSync <= 1'b0;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
            capMeta <= echoCaptureIn;
            capSync <= capMeta;
        end
    end

    // registers
    ued_pkg::ued_cfg_t cfg;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    logic ack;
    logic wrHit;
    logic [3:0] regIdx;
    logic startFine;
    logic startCoarse;

    assign regIdx = avs_address[5:2];
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wrHit = avs_write && ack;

    always_ff @(posedge clk) begin
        if (!rstn) ack <= 1'b0;
        else ack <= (avs_read || avs_write) && !ack;
    end

    logic fineBusy, fineTrig, fineDone, fineTimedOut;
    logic coarseBusy, coarseTrig, coarseDone, coarseTimedOut;
    logic [ued_pkg::FINE_WIDTH-1:0] fineCount;
    logic [ued_pkg::COARSE_WIDTH-1:0] coarseCount;
    logic anyBusy;

    // one trigger pin is shared, so a start while either runs is ignored
    assign anyBusy = fineBusy || coarseBusy;
    assign startFine = wrHit && regIdx == ued_pkg::REG_CTRL && !anyBusy
        && avs_writedata[ued_pkg::CTRL_START_FINE];
    assign startCoarse = wrHit && regIdx == ued_pkg::REG_CTRL && !anyBusy
        && !avs_writedata[ued_pkg::CTRL_START_FINE]
        && avs_writedata[ued_pkg::CTRL_START_COARSE];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg <= ued_pkg::CFG_RESET;
            pinSetup <= ued_pkg::PIN_SETUP_RESET;
        end else if (wrHit && !anyBusy) begin
            // frozen during a measurement so the pin cannot move under it
            if (regIdx == ued_pkg::REG_CONFIG) begin
                cfg <= '{avs_writedata[14:12], avs_writedata[10:8],
                         avs_writedata[6:4], avs_writedata[2:0]};
            end
            if (regIdx == ued_pkg::REG_PIN_SETUP) begin
                pinSetup <= avs_writedata[15:0]; // [R6]
            end
        end
    end

    logic [3:0] events;
    assign events = {coarseDone && coarseTimedOut,
                     coarseDone && !coarseTimedOut,
                     fineDone && fineTimedOut, fineDone && !fineTimedOut};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irqStatus <= 4'h0;
            irqMask <= 4'h0;
        end else begin
            // a new event wins over a write-one-to-clear in the same cycle
            if (wrHit && regIdx == ued_pkg::REG_IRQ_STATUS)
                irqStatus <= (irqStatus & ~avs_writedata[3:0]) | events;
            else
                irqStatus <= irqStatus | events; // [R9]
            if (wrHit && regIdx == ued_pkg::REG_IRQ_MASK)
                irqMask <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) irq <= 1'b0;
        else irq <= |(irqStatus & irqMask);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            unique case (regIdx)
                ued_pkg::REG_CONFIG: avs_readdata <= {17'h0_0000,
                    cfg.echoBit, 1'b0, cfg.echoPort, 1'b0, cfg.trigBit, 1'b0,
                    cfg.trigPort};
                ued_pkg::REG_PIN_SETUP: avs_readdata <= {16'h0000, pinSetup};
                ued_pkg::REG_STATUS: avs_readdata <= {28'h000_0000,
                    coarseTimedOut, fineTimedOut, coarseBusy, fineBusy};
                ued_pkg::REG_FINE_LO: avs_readdata <= fineCount[31:0];
                ued_pkg::REG_FINE_HI: avs_readdata <= fineCount[63:32];
                ued_pkg::REG_COARSE: avs_readdata <= coarseCount;
                ued_pkg::REG_IRQ_STATUS: avs_readdata <= {28'h000_0000,
                    irqStatus};
                ued_pkg::REG_IRQ_MASK: avs_readdata <= {28'h000_0000, irqMask};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // echo selection: fine uses the fixed capture pin, coarse any pin
    logic coarseEcho;
    assign coarseEcho = pinSync[ued_pkg::pinIndex(cfg.echoPort, cfg.echoBit)
                                % NPINS]; // [R7]

    ued_delay_engine #(
        .WIDTH(ued_pkg::FINE_WIDTH),
        .STEP(1)
    ) fineEngine (
        .clk(clk),
        .rstn(rstn),
        .start(startFine),
        .tick(tick),
        .echo(capSync),
        .limit(ued_pkg::FINE_WIDTH'(TIMEOUT_TICKS)),
        .busy(fineBusy),
        .trigger(fineTrig),
        .done(fineDone),
        .timedOut(fineTimedOut),
        .count(fineCount)
    );

    ued_delay_engine #(
        .WIDTH(ued_pkg::COARSE_WIDTH),
        .STEP(ued_pkg::COARSE_STEP)
    ) coarseEngine (
        .clk(clk),
        .rstn(rstn),
        .start(startCoarse),
        .tick(tick),
        .echo(coarseEcho),
        .limit(ued_pkg::COARSE_WIDTH'(TIMEOUT_TICKS)),
        .busy(coarseBusy),
        .trigger(coarseTrig),
        .done(coarseDone),
        .timedOut(coarseTimedOut),
        .count(coarseCount)
    );

    // trigger pin mux; out of reset the selected pin is always driven, idle low
    logic [NPINS-1:0] trigSel;
    always_comb begin
        trigSel = '0;
        trigSel[ued_pkg::pinIndex(cfg.trigPort, cfg.trigBit) % NPINS] = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trigOut <= '0;
            trigOe <= '0;
        end else begin
            trigOe <= trigSel; // [R6]
            trigOut <= (fineTrig || coarseTrig) ? trigSel : '0; // [R4]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_ONE_TRIG_PIN: assert property ($countones(trigOut) <= 1) // [R6]
        else $error("more than one trigger pin active");
    AST_TRIG_FOLLOWS: assert property (
        fineTrig || coarseTrig |=> trigOut == $past(trigSel))
        else $error("trigger pin not driven while measuring"); // [R4]
    AST_TIMEOUT_FLAG: assert property (
        fineDone && fineTimedOut |=> irqStatus[ued_pkg::EV_FINE_TIMEOUT])
        else $error("fine timeout not flagged"); // [R9]
    AST_SETUP_STABLE: assert property (
        anyBusy |=> $stable(pinSetup))
        else $error("pin setup changed during measurement"); // [R6]
endmodule : ued_echo_timer
`default_nettype wire

// ---- src/ued_pkg.sv ----
/*
 Shared constants, types and helpers for the ultrasonic echo delay timer.
 Assumes a 100 MHz system clock and a 12 MHz measurement time base.
*/
// Notes on behaviour
// R1: sensor emits a 40 kHz burst while its trigger input is high.
// R2: sensor raises echo output when the reflected burst arrives.
// R3: time runs from trigger assertion to the first active echo sample.
// R4: trigger and echo are active high; give up after 100 ms.
// R5: result is a count of 12 MHz ticks, not a distance.
// R6: trigger pin chosen by port and bit; pin setup word passes unchanged.
// R7: coarse engine watches any pin chosen by port and bit.
// R8: only active-high pins supported; inverted sensors need another engine.
// R9: on timeout drop the trigger and flag a timeout instead of a count.
// R10: fine counter 64 bits, coarse counter 32 bits; no wrap in timeout.
package ued_pkg;
    localparam int CLK_MHZ = 100;
    localparam int TICK_MHZ = 12;
    localparam int TIMEOUT_MS = 100;
    localparam int TIMEOUT_TICKS_DEF = TIMEOUT_MS * TICK_MHZ * 1000;
    localparam int FINE_WIDTH = 64;
    localparam int COARSE_WIDTH = 32;
    localparam int COARSE_STEP = 4;
    localparam int PORT_BITS = 8;
    // active levels are fixed high for this sensor family
    localparam logic TRIGGER_ACTIVE_LEVEL = 1'b1;
    localparam logic ECHO_ACTIVE_LEVEL = 1'b1;
    // register word indices, taken from address bits 5:2
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_PIN_SETUP = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_FINE_LO = 4'h4;
    localparam logic [3:0] REG_FINE_HI = 4'h5;
    localparam logic [3:0] REG_COARSE = 4'h6;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h7;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;
    // control bits
    localparam int CTRL_START_FINE = 0;
    localparam int CTRL_START_COARSE = 1;
    // irq status and irq mask bit positions
    localparam int EV_FINE_DONE = 0;
    localparam int EV_FINE_TIMEOUT = 1;
    localparam int EV_COARSE_DONE = 2;
    localparam int EV_COARSE_TIMEOUT = 3;
    localparam logic [15:0] PIN_SETUP_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_WAIT = 2'b01
    } ued_eng_state_t;

    // config register: 3-bit fields at nibble boundaries
    typedef struct packed {
        logic [2:0] echoBit;
        logic [2:0] echoPort;
        logic [2:0] trigBit;
        logic [2:0] trigPort;
    } ued_cfg_t;

    localparam ued_cfg_t CFG_RESET = '{3'h0, 3'h0, 3'h0, 3'h0};

    function automatic int pinIndex(input logic [2:0] port,
                                    input logic [2:0] bitNo);
        pinIndex = int'(port) * PORT_BITS + int'(bitNo);
    endfunction : pinIndex
endpackage : ued_pkg

// ---- src/ued_delay_engine.sv ----
/*
 One delay engine: drives the trigger, counts ticks until echo or timeout.
 Assumes echo is already synchronised and tick is a one-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module ued_delay_engine #(
    parameter int WIDTH = 64,
    parameter int STEP = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic tick,
    input wire logic echo,
    input wire logic [WIDTH-1:0] limit,
    output logic busy,
    output logic trigger,
    output logic done,
    output logic timedOut,
    output logic [WIDTH-1:0] count
);
    // phase is eight bits wide, so STEP cannot exceed 255
    if (WIDTH < 32 || STEP < 1 || STEP > 255) begin : g_bad_params
        $error("ued_delay_engine: unsupported WIDTH or STEP");
    end

    ued_pkg::ued_eng_state_t state;
    logic [7:0] phase;
    logic hit;
    logic expire;

    // coarse engine only looks at echo on every STEP-th tick slot
    assign hit = (echo == ued_pkg::ECHO_ACTIVE_LEVEL) && (phase == 8'h00);
    assign expire = (count >= limit);
    assign busy = (state == ued_pkg::ENG_WAIT);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ued_pkg::ENG_IDLE;
        end else begin
            unique case (state)
                ued_pkg::ENG_IDLE: if (start) state <= ued_pkg::ENG_WAIT;
                ued_pkg::ENG_WAIT: if (hit || expire) begin
                    state <= ued_pkg::ENG_IDLE; // [R3] [R9]
                end
                default: state <= ued_pkg::ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trigger <= ~ued_pkg::TRIGGER_ACTIVE_LEVEL;
        end else if (!busy && start) begin
            trigger <= ued_pkg::TRIGGER_ACTIVE_LEVEL; // [R3] [R4] [R8]
        end else if (busy && (hit || expire)) begin
            trigger <= ~ued_pkg::TRIGGER_ACTIVE_LEVEL; // [R9]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= '0;
            phase <= 8'h00;
        end else if (!busy && start) begin
            count <= '0;
            phase <= 8'h00;
        end else if (busy && tick && !hit && !expire) begin
            count <= count + 1'b1; // [R5]
            phase <= (phase == 8'(STEP - 1)) ? 8'h00 : phase + 8'h01; // [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            done <= 1'b0;
            timedOut <= 1'b0;
        end else begin
            done <= busy && (hit || expire);
            // echo seen in the expiry cycle still counts as a result
            if (busy && (hit || expire)) timedOut <= !hit; // [R9]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_launch;
        !busy && start;
    endsequence
    sequence s_armed;
        busy && trigger && count == '0;
    endsequence

    AST_LAUNCH: assert property (s_launch |=> s_armed) // [R3]
        else $error("start did not raise trigger with cleared count");
    AST_TRIG_HELD: assert property (busy |-> trigger) // [R4]
        else $error("trigger low while waiting for echo");
    AST_COUNT_TICK: assert property (
        busy && tick && !hit && !expire |=> count == $past(count) + 1'b1)
        else $error("tick not counted"); // [R5]
    AST_ECHO_END: assert property (
        busy && hit |=> done && !timedOut && !trigger && !busy)
        else $error("echo did not end measurement"); // [R3]
    AST_TIMEOUT_END: assert property (
        busy && expire && !hit |=> done && timedOut && !trigger)
        else $error("timeout did not drop trigger"); // [R9]
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle"); // [R3]
endmodule : ued_delay_engine
`default_nettype wire

// ---- verification/ued_sensor_model.sv ----
/*
 Behavioural ultrasonic sensor: echo rises a set delay after the trigger.
 Assumes the bench clock; the sensor has no reset pin of its own.
*/
`timescale 1ns/1ps
`default_nettype none
module ued_sensor_model (
    input wire logic clk,
    input wire logic trig,
    input wire logic [15:0] delayCycles,
    input wire logic mute,
    output logic echo
);
    logic [15:0] flight;
    // mute stands for a reflection that never comes back
    // an unknown trigger before reset counts as low, so no false echo
    always @(posedge clk) begin
        if (trig !== 1'b1) begin
            flight <= 16'h0000;
            echo <= 1'b0;
        end else if (flight == delayCycles) begin
            echo <= !mute;
        end else begin
            flight <= flight + 16'h0001;
        end
    end
endmodule : ued_sensor_model
`default_nettype wire

// ---- verification/ued_echo_timer_test.sv ----
/*
 Self-checking bench for the echo timer: bus tasks, scenarios, verdict.
 Assumes the sensor model sits on the selected trigger and echo pins.
*/
`timescale 1ns/1ps
`default_nettype none
module ued_echo_timer_test;
    localparam int TMO = 200;
    localparam int D = 300;
    logic clk, rstn, avs_read, avs_write, irq, avs_waitrequest, echo, mute;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, pinIn, trigOut, trigOe;
    logic [15:0] pinSetup, delayCycles;
    logic [4:0] trigIdx, echoIdx;
    int num_errors, compares;

    // only the configured pin reaches the sensor
    wire logic sensTrig = trigOut[trigIdx] & trigOe[trigIdx];
    assign pinIn = {31'h0, echo} << echoIdx;

    ued_echo_timer #(.NPORTS(4), .TIMEOUT_TICKS(TMO)) ued_echo_timer_inst (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .pinIn(pinIn),
        .echoCaptureIn(echo), .trigOut(trigOut), .trigOe(trigOe),
        .pinSetup(pinSetup));
    ued_sensor_model ued_sensor_model_inst (.clk(clk), .trig(sensTrig),
        .delayCycles(delayCycles), .mute(mute), .echo(echo));

    task report_and_stop;
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time,
                     seen, exp);
        end
    endtask : check

    // request held until waitrequest is seen low at a rising edge;
    // a hang is left to the watchdog
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task wait_idle;
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h3;
        while (s[1:0] !== 2'b00 && n < 1000) begin
            rd(6'h0C, s);
            n++;
        end
        check(64'(n < 1000), 64'h1);
    endtask : wait_idle

    task test_reset;
        logic [31:0] q;
        check(64'(trigOe), 64'h1);
        check(64'({trigOut, pinSetup, irq}), 64'h0);
        rd(6'h04, q);
        check(64'(q), 64'h0);
        wr(6'h3C, 32'hFFFF_FFFF);
        rd(6'h3C, q);
        check(64'(q), 64'h0);
    endtask : test_reset

    // trigger on port 2 bit 5, coarse echo on port 1 bit 3
    task test_fine;
        logic [31:0] q;
        trigIdx = 5'h15;
        echoIdx = 5'h0B;
        delayCycles <= 16'(D);
        wr(6'h04, 32'h0000_3152);
        wr(6'h08, 32'h0000_A5C3);
        wr(6'h20, 32'h0);
        settle;
        check(64'(pinSetup), 64'hA5C3);
        check(64'(trigOe), 64'h0020_0000);
        wr(6'h00, 32'h1);
        wr(6'h00, 32'h2);
        rd(6'h0C, q);
        check(64'(q), 64'h1);
        wr(6'h04, 32'h0);
        rd(6'h04, q);
        check(64'(q), 64'h3152);
        check(64'(trigOut), 64'h0020_0000);
        wait_idle;
        check(64'(trigOut), 64'h0);
        rd(6'h10, q);
        check(64'(q >= 33 && q <= 40), 64'h1);
        rd(6'h14, q);
        check(64'(q), 64'h0);
        rd(6'h0C, q);
        check(64'(q), 64'h0);
        rd(6'h1C, q);
        check(64'(q), 64'h1);
        check(64'(irq), 64'h0);
        wr(6'h20, 32'h1);
        settle;
        check(64'(irq), 64'h1);
        wr(6'h1C, 32'h1);
        settle;
        rd(6'h1C, q);
        check(64'({q, irq}), 64'h0);
    endtask : test_fine

    task test_coarse;
        logic [31:0] q;
        wr(6'h00, 32'h2);
        wait_idle;
        rd(6'h18, q);
        check(64'(q[1:0]), 64'h0);
        check(64'(q >= 32 && q <= 44), 64'h1);
        rd(6'h1C, q);
        check(64'(q), 64'h4);
        wr(6'h1C, 32'hF);
        // both start bits: the fine engine takes precedence
        wr(6'h00, 32'h3);
        rd(6'h0C, q);
        check(64'(q), 64'h1);
        wait_idle;
        rd(6'h1C, q);
        check(64'(q), 64'h1);
        wr(6'h1C, 32'hF);
    endtask : test_coarse

    // a sensor that never answers high must end in a timeout
    task test_timeout;
        logic [31:0] q;
        mute <= 1'b1;
        wr(6'h20, 32'h2);
        wr(6'h00, 32'h1);
        wait_idle;
        check(64'(trigOut), 64'h0);
        rd(6'h10, q);
        check(64'(q), 64'(TMO));
        rd(6'h0C, q);
        check(64'(q), 64'h4);
        rd(6'h1C, q);
        check(64'(q), 64'h2);
        check(64'(irq), 64'h1);
        wr(6'h20, 32'h8);
        wr(6'h00, 32'h2);
        wait_idle;
        check(64'(trigOut), 64'h0);
        rd(6'h18, q);
        check(64'(q), 64'(TMO));
        rd(6'h0C, q);
        check(64'(q), 64'hC);
        rd(6'h1C, q);
        check(64'(q), 64'hA);
        check(64'(irq), 64'h1);
        mute <= 1'b0;
    endtask : test_timeout

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        // all scenarios need about 4500 cycles; allow a wide margin
        #200000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        num_errors = 0;
        compares = 0;
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        delayCycles = 16'h0000;
        mute = 1'b0;
        trigIdx = 5'h00;
        echoIdx = 5'h00;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        settle;
        test_reset;
        test_fine;
        test_coarse;
        test_timeout;
        report_and_stop;
    end
endmodule : ued_echo_timer_test
`default_nettype wire
